// ### rtl/dlsl_pkg.sv
`default_nettype none
package dlsl_pkg;
	localparam int KEY_W = 32;
	localparam int VOTE_MIN = 28;
	localparam int PROT_W = 2;
	// arbitrary neutral key value
	localparam logic [KEY_W-1:0] KEY_DEFAULT = 32'h5a3c_96e1;
	localparam logic [PROT_W-1:0] PROT_NONE = 2'h0;
	localparam logic [KEY_W-1:0] HOLD_RST = 32'h0000_0000;
	typedef enum logic [1:0]
	{
		DLSL_EVAL = 2'b01,
		DLSL_RUN = 2'b10
	} dlsl_state_t;
endpackage
`default_nettype wire

// ### rtl/dlsl_vote.sv
`default_nettype none
module dlsl_vote #(
	parameter int W = 32,
	parameter int THR = 28
) (
	input wire logic [W-1:0] cells,
	input wire logic [W-1:0] key,
	output logic hit
);
	logic [7:0] cnt;
	always_comb
	begin
		cnt = 8'h00;
		for (int i = 0; i < W; i++)
		begin
			cnt = cnt + {7'h00, (cells[i] == key[i])};
		end
		hit = (cnt >= 8'(THR));
	end
endmodule // dlsl_vote
`default_nettype wire

// ### rtl/dlsl_top.sv
// Overview of operation
// - 32 nonvolatile latch bits compared with key
// - at least 28 matching bits means locked
// - locked: debug, test, programming ports stay off
// - locked: latch contents cannot be changed
// - lock needs load, program, then reset
// - latch output sets lock only at reset; key writes check it every cycle
// - key write only with no flash protection
// - latch contents readable on rd_req whenever rst is low, locked or not, without debug port enable
// - protection raised only while port enabled, cleared by full erase
// - block operation only if block security allows
// - whole device erase, program, verify allowed only while port enabled
`default_nettype none
module dlsl_top
	import dlsl_pkg::*;
#(
	parameter logic [dlsl_pkg::KEY_W-1:0] KEY = dlsl_pkg::KEY_DEFAULT
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic por_load,
	input wire logic [dlsl_pkg::KEY_W-1:0] por_cells,
	input wire logic hold_load,
	input wire logic [dlsl_pkg::KEY_W-1:0] hold_data,
	input wire logic nv_prog,
	input wire logic rd_req,
	input wire logic prot_raise,
	input wire logic [dlsl_pkg::PROT_W-1:0] prot_level,
	input wire logic full_erase,
	input wire logic blk_req,
	input wire logic blk_allowed,
	input wire logic dev_req,
	input wire logic dbg_req,
	output logic port_en_r,
	output logic dbg_en_r,
	output logic locked_r,
	output logic wr_ack_r,
	output logic wr_nak_r,
	output logic [dlsl_pkg::KEY_W-1:0] rd_data_r,
	output logic rd_valid_r,
	output logic [dlsl_pkg::PROT_W-1:0] prot_r,
	output logic blk_grant_r,
	output logic dev_grant_r
);
	import dlsl_pkg::*;

	logic [KEY_W-1:0] cells_r;
	logic [KEY_W-1:0] cells_nxt;
	logic [KEY_W-1:0] hold_r;
	logic [KEY_W-1:0] hold_nxt;
	dlsl_state_t st_r;
	dlsl_state_t st_nxt;
	logic live_hit;
	logic wr_ok;
	logic port_en_nxt;
	logic dbg_en_nxt;
	logic locked_nxt;
	logic wr_ack_nxt;
	logic wr_nak_nxt;
	logic [KEY_W-1:0] rd_data_nxt;
	logic rd_valid_nxt;
	logic [PROT_W-1:0] prot_nxt;
	logic blk_grant_nxt;
	logic dev_grant_nxt;

	dlsl_vote #(
		.W(KEY_W),
		.THR(VOTE_MIN)
	) u_vote (
		.cells(cells_r),
		.key(KEY),
		.hit(live_hit)
	);

	// nonvolatile cells: untouched by rst, loaded at power-on
	always_comb
	begin
		wr_ok = !live_hit && (prot_r == PROT_NONE);
		cells_nxt = cells_r;
		hold_nxt = hold_r;
		wr_ack_nxt = 1'b0;
		wr_nak_nxt = 1'b0;
		if (por_load)
		begin
			cells_nxt = por_cells;
		end
		else if (hold_load || nv_prog)
		begin
			if (wr_ok && port_en_r)
			begin
				wr_ack_nxt = 1'b1;
				if (hold_load)
				begin
					hold_nxt = hold_data;
				end
				else
				begin
					cells_nxt = hold_r;
				end
			end
			else
			begin
				wr_nak_nxt = 1'b1;
			end
		end
		if (rst)
		begin
			hold_nxt = HOLD_RST;
			wr_ack_nxt = 1'b0;
			wr_nak_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		cells_r <= cells_nxt;
		hold_r <= hold_nxt;
		wr_ack_r <= wr_ack_nxt;
		wr_nak_r <= wr_nak_nxt;
	end

	// lock decision and port enables
	always_comb
	begin
		st_nxt = st_r;
		locked_nxt = locked_r;
		port_en_nxt = port_en_r;
		dbg_en_nxt = dbg_en_r;
		case (st_r)
			DLSL_EVAL:
			begin
				locked_nxt = live_hit;
				port_en_nxt = !live_hit;
				st_nxt = DLSL_RUN;
			end
			DLSL_RUN:
			begin
				if (dbg_req && !locked_r)
				begin
					dbg_en_nxt = 1'b1;
				end
				// a locked part never reopens a port until the next reset
				if (locked_r)
				begin
					port_en_nxt = 1'b0;
					dbg_en_nxt = 1'b0;
				end
			end
			default:
			begin
				st_nxt = DLSL_EVAL;
				locked_nxt = 1'b1;
				port_en_nxt = 1'b0;
				dbg_en_nxt = 1'b0;
			end
		endcase
		if (rst)
		begin
			st_nxt = DLSL_EVAL;
			locked_nxt = 1'b1;
			port_en_nxt = 1'b0;
			dbg_en_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		st_r <= st_nxt;
		locked_r <= locked_nxt;
		port_en_r <= port_en_nxt;
		dbg_en_r <= dbg_en_nxt;
	end

	// readout, flash protection and flash operation grants
	always_comb
	begin
		rd_valid_nxt = rd_req;
		rd_data_nxt = rd_req ? cells_r : rd_data_r;
		prot_nxt = prot_r;
		blk_grant_nxt = 1'b0;
		dev_grant_nxt = 1'b0;
		if (port_en_r)
		begin
			if (full_erase)
			begin
				prot_nxt = PROT_NONE;
			end
			else if (prot_raise && (prot_level > prot_r))
			begin
				prot_nxt = prot_level;
			end
			blk_grant_nxt = blk_req && blk_allowed;
			dev_grant_nxt = dev_req;
		end
		if (rst)
		begin
			rd_valid_nxt = 1'b0;
			rd_data_nxt = HOLD_RST;
			blk_grant_nxt = 1'b0;
			dev_grant_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		rd_valid_r <= rd_valid_nxt;
		rd_data_r <= rd_data_nxt;
		prot_r <= prot_nxt;
		blk_grant_r <= blk_grant_nxt;
		dev_grant_r <= dev_grant_nxt;
	end
endmodule // dlsl_top
`default_nettype wire

// ### dv/dlsl_checker.sv
`default_nettype none
module dlsl_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic port_en_r,
	input wire logic dbg_en_r,
	input wire logic locked_r
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	lk_port_a: assert property (locked_r |-> !port_en_r) else $error("port");
	lk_dbg_a: assert property (locked_r |-> !dbg_en_r) else $error("dbg");
	lk_hold_a: assert property (!$past(rst) |=> $stable(locked_r)) else $error("hold");
	pe_hold_a: assert property (!$past(rst) |=> $stable(port_en_r)) else $error("port hold");
	pe_eval_a: assert property (!$past(rst) |-> port_en_r != locked_r) else $error("eval");
	rel_safe_a: assert property ($fell(rst) |-> locked_r && !port_en_r) else $error("release");
	dbg_port_a: assert property (dbg_en_r |-> port_en_r) else $error("dbg port");
	dbg_keep_a: assert property (dbg_en_r |=> dbg_en_r) else $error("keep");
	cover property (locked_r);
	cover property (dbg_en_r);
	cover property (port_en_r);
endmodule // dlsl_chk
bind dlsl_top dlsl_chk chk_u (.*);
`default_nettype wire

// ### dv/dlsl_prog.sv
`default_nettype none
module dlsl_prog (
	input wire logic clk,
	input wire logic go,
	input wire logic [31:0] key,
	output logic hold_load = '0,
	output logic [31:0] hold_data = '0,
	output logic nv_prog = '0
);
	timeunit 1ns;
	timeprecision 1ns;
	always @(posedge clk)
	begin
		hold_load <= go;
		hold_data <= go ? key : ~key;
		nv_prog <= hold_load;
	end
endmodule // dlsl_prog
`default_nettype wire

// ### dv/dlsl_top_tb.sv
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; $display("FAIL %0t %h %h", $time, a, b); end end
`default_nettype none
module dlsl_top_tb
	import dlsl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst = 1, v;
	logic [7:0] rq = '0;
	logic [31:0] m, rd_data_r, hold_data, por_cells = '0;
	logic [1:0] prot_r;
	wire logic go, por_load, rd_req, prot_raise, full_erase, blk_req, dev_req, dbg_req;
	logic hold_load, nv_prog, port_en_r, dbg_en_r, locked_r, wr_ack_r, wr_nak_r, rd_valid_r, blk_grant_r, dev_grant_r;
	int n_fail = 0, check_count = 0, cyc = 0;
	assign {go, dbg_req, dev_req, prot_raise, full_erase, blk_req, rd_req, por_load} = rq;
	dlsl_top dut_u (.blk_allowed(por_cells[0]), .prot_level(2'h1), .*);
	dlsl_prog prog_u (.key(por_cells), .*);
	initial forever #20 clk = ~clk;
	always @(posedge clk)
		if (++cyc > 999)
			stop_test(1);
	task p(int b, logic [31:0] a = '0);
		@(posedge clk);
		rq[b] <= 1'h1;
		por_cells <= a;
		@(posedge clk);
		rq <= '0;
		@(negedge clk);
	endtask
	task rs;
		@(posedge clk);
		rst <= 1'h1;
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		repeat (3) @(negedge clk);
	endtask
	task wr(logic [31:0] d, logic ok);
		p(7, d);
		repeat (2) @(negedge clk);
		`CHK({wr_ack_r, wr_nak_r}, {ok, !ok})
	endtask
	task stop_test(int f = 0);
		n_fail += f;
		$display("%0d checks %0d fails", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		void'($urandom(32'h34ed37be));
		for (int i = 0; i < 3; i++)
		begin
			m = KEY_DEFAULT ^ (i == 0 ? $urandom : 32'h1f >> i);
			v = $countones(~(m ^ KEY_DEFAULT)) >= VOTE_MIN;
			p(0, m);
			rs;
			p(3);
			`CHK({locked_r, port_en_r}, {v, !v})
			p(6);
			`CHK(dbg_en_r, !v)
			p(1);
			`CHK({rd_valid_r, rd_data_r}, {1'b1, m})
			p(5);
			`CHK(dev_grant_r, !v)
			p(2, $urandom);
			`CHK(blk_grant_r, por_cells[0] & !v)
			$display("vote case done");
		end
		p(0, ~KEY_DEFAULT);
		rs;
		p(3);
		`CHK(prot_r, PROT_NONE)
		p(4);
		`CHK(prot_r, 2'h1)
		wr(KEY_DEFAULT, 1'h0);
		p(3);
		`CHK(prot_r, PROT_NONE)
		wr(KEY_DEFAULT, 1'h1);
		`CHK(locked_r, 1'h0)
		rs;
		`CHK(locked_r, 1'h1)
		wr('0, 1'h0);
		$display("write case done");
		stop_test();
	end
endmodule // dlsl_top_tb
`default_nettype wire
